/* pkg/ucr_pkg.sv */
// Package with register map, reset values and field positions of the channel.
package ucr_pkg;
    // ************************************************************
    // Register byte addresses.
    // ************************************************************
    localparam logic [7:0] ADDR_DIV_LOW      = 8'h00;
    localparam logic [7:0] ADDR_DIV_HIGH     = 8'h04;
    localparam logic [7:0] ADDR_MODEM_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RESUME_1     = 8'h0C;
    localparam logic [7:0] ADDR_RESUME_2     = 8'h10;
    localparam logic [7:0] ADDR_PAUSE_1      = 8'h14;
    localparam logic [7:0] ADDR_PAUSE_2      = 8'h18;
    localparam logic [7:0] ADDR_CONTROL      = 8'h1C;
    // ************************************************************
    // Reset values and field positions.
    // ************************************************************
    localparam logic [15:0] DIVISOR_INIT    = 16'h0001;
    localparam logic [7:0]  CHAR_RESET      = 8'h00;
    localparam logic [3:0]  DELTA_RESET     = 4'h0;
    localparam int          CTRL_SLEEP_BIT  = 0;
    localparam int          CTRL_RTS_BIT    = 1;
    localparam int          CTRL_DTR_BIT    = 2;
    localparam int          CTRL_OP2_BIT    = 3;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

/* hdl/ucr_modem_status.sv */
// Modem status byte: change flags and inverted input levels.
`timescale 1ns/1ps
module ucr_modem_status
    import ucr_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [3:0] modem_in_n,
    input  wire logic       clear_delta,
    output logic      [7:0] status
);
    logic [3:0] prev_n;
    logic [3:0] delta;
    logic [3:0] next_delta;

    always_ff @(posedge aclk) begin
        prev_n <= modem_in_n;
    end

    // Change set wins over a clear by read in the same cycle.
    always_comb begin
        next_delta = clear_delta ? DELTA_RESET : delta;
        next_delta = next_delta | (prev_n ^ modem_in_n);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            delta <= DELTA_RESET;
        end else begin
            delta <= next_delta;
        end
    end

    assign status = {~modem_in_n, delta};

    a_delta_reset: assert property (@(posedge aclk)
        !aresetn |=> delta == DELTA_RESET)
        else $error("Change flags not cleared by reset.");
    a_level_invert: assert property (@(posedge aclk)
        status[7:4] == ~modem_in_n)
        else $error("Modem levels not shown inverted.");
endmodule

/* hdl/ucr_channel.sv */
// Channel register bank with AXI4-Lite slave, reset state and sleep isolation.
//
// Summary of operation
// - Four flow control characters, reset to zero.
// - Divisor initialises to one at power-up only.
// - Reset pin keeps divisor, resets other registers.
// - Modem change bits clear; levels shown inverted.
// - Sleep isolates bus and receive inputs.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module ucr_channel
    import ucr_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rx_in,
    input  wire logic [3:0]  modem_in_n,
    output logic             rx_held,
    output logic             tx_out,
    output logic             rts_n,
    output logic             dtr_n,
    output logic             general_output_two_n,
    output logic             rx_transfer_ready_n,
    output logic             tx_transfer_ready_n,
    output logic             irq_out,
    output logic             irq_oe
);
    // ************************************************************
    // Storage.
    // ************************************************************
    logic [15:0] divisor = DIVISOR_INIT;
    logic [7:0]  flow_char [4];
    logic [3:0]  control;
    logic [7:0]  modem_status_reg;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [7:0]  w_byte;
    logic        w_lane0;
    logic        do_write;
    logic        do_read;
    logic        read_hit;
    logic [7:0]  read_byte;
    logic        clear_delta;
    logic        sleeping;
    logic        rx_pin;

    assign sleeping = control[CTRL_SLEEP_BIT];

    // ************************************************************
    // Write channel.
    // ************************************************************
    // While asleep the bus inputs are ignored, so no handshake starts.
    assign s_axi_awready = !aw_held && !s_axi_bvalid && !sleeping;
    assign s_axi_wready  = !w_held && !s_axi_bvalid && !sleeping;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_byte  <= 8'h00;
            w_lane0 <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held  <= 1'b1;
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr <= ADDR_CONTROL && aw_addr[1:0] == 2'h0)
                            ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // The divisor has no reset branch: only its power-up value applies.
    always_ff @(posedge aclk) begin
        if (aresetn && do_write && w_lane0) begin
            if (aw_addr == ADDR_DIV_LOW) begin
                divisor[7:0] <= w_byte;
            end
            if (aw_addr == ADDR_DIV_HIGH) begin
                divisor[15:8] <= w_byte;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_char
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    flow_char[gi] <= CHAR_RESET;
                end else if (do_write && w_lane0 &&
                             aw_addr == ADDR_RESUME_1 + 8'(4 * gi)) begin
                    flow_char[gi] <= w_byte;
                end
            end
        end
    endgenerate

    // Sleep is left by the reset pin only, since the bus is isolated.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control <= 4'h0;
        end else if (do_write && w_lane0 && aw_addr == ADDR_CONTROL) begin
            control <= w_byte[3:0];
        end
    end

    // ************************************************************
    // Read channel.
    // ************************************************************
    assign s_axi_arready = !s_axi_rvalid && !sleeping;
    assign do_read       = s_axi_arvalid && s_axi_arready;
    assign clear_delta   = do_read && s_axi_araddr == ADDR_MODEM_STATUS;

    always_comb begin
        read_hit  = 1'b1;
        read_byte = 8'h00;
        unique case (s_axi_araddr)
            ADDR_DIV_LOW:      read_byte = divisor[7:0];
            ADDR_DIV_HIGH:     read_byte = divisor[15:8];
            ADDR_MODEM_STATUS: read_byte = modem_status_reg;
            ADDR_RESUME_1:     read_byte = flow_char[0];
            ADDR_RESUME_2:     read_byte = flow_char[1];
            ADDR_PAUSE_1:      read_byte = flow_char[2];
            ADDR_PAUSE_2:      read_byte = flow_char[3];
            ADDR_CONTROL:      read_byte = {4'h0, control};
            default:           read_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, read_byte};
            s_axi_rresp  <= read_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ucr_modem_status u_modem (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .modem_in_n  (modem_in_n),
        .clear_delta (clear_delta),
        .status      (modem_status_reg)
    );

    // ************************************************************
    // Serial side and pins.
    // ************************************************************
    // The receive input holds its last sampled value while asleep.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_pin <= 1'b1;
        end else if (!sleeping) begin
            rx_pin <= rx_in;
        end
    end
    assign rx_held = rx_pin;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_out               <= 1'b1;
            rts_n                <= 1'b1;
            dtr_n                <= 1'b1;
            general_output_two_n <= 1'b1;
            rx_transfer_ready_n  <= 1'b1;
            tx_transfer_ready_n  <= 1'b0;
            irq_out              <= 1'b0;
            irq_oe               <= 1'b0;
        end else begin
            tx_out               <= 1'b1;
            rts_n                <= ~control[CTRL_RTS_BIT];
            dtr_n                <= ~control[CTRL_DTR_BIT];
            general_output_two_n <= ~control[CTRL_OP2_BIT];
            rx_transfer_ready_n  <= 1'b1;
            tx_transfer_ready_n  <= 1'b0;
            irq_out              <= 1'b0;
            irq_oe               <= 1'b0;
        end
    end

    a_char_reset: assert property (@(posedge aclk)
        !aresetn |=> flow_char[0] == 8'h00 && flow_char[3] == 8'h00)
        else $error("Flow characters not cleared by reset.");
    a_divisor_keep: assert property (@(posedge aclk)
        !aresetn |=> $stable(divisor))
        else $error("Divisor changed under reset.");
    a_sleep_isolate: assert property (@(posedge aclk) disable iff (!aresetn)
        sleeping |-> !s_axi_awready && !s_axi_arready && !s_axi_wready)
        else $error("Bus accepted while asleep.");
    a_rx_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
        sleeping && $past(sleeping) |-> $stable(rx_held))
        else $error("Receive input moved while asleep.");
    a_pin_reset: assert property (@(posedge aclk)
        !aresetn |=> tx_out && rts_n && dtr_n && general_output_two_n
                     && rx_transfer_ready_n && !tx_transfer_ready_n
                     && !irq_oe)
        else $error("Pin reset levels wrong.");
    a_div_write: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && w_lane0 && aw_addr == ADDR_DIV_LOW
        |=> divisor[7:0] == $past(w_byte))
        else $error("Divisor low byte not written.");
    a_ctrl_reset: assert property (@(posedge aclk)
        !aresetn |=> control == 4'h0 && !s_axi_bvalid)
        else $error("Control not reset.");
    a_char_write: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && w_lane0 && aw_addr == ADDR_PAUSE_2
        |=> flow_char[3] == $past(w_byte))
        else $error("Pause character not written.");
endmodule

/* sim/ucr_line_peer.sv */
// Far-side model of the serial line peer driving receive and modem inputs.
`timescale 1ns/1ps
module ucr_line_peer (
    input  wire logic       aclk,
    input  wire logic       rx_level,
    input  wire logic [3:0] modem_level,
    input  wire logic       tx_out,
    output logic            rx_in,
    output logic      [3:0] modem_in_n
);
    // The peer moves its lines only just after a clock edge.
    always_ff @(posedge aclk) begin
        rx_in      <= rx_level;
        modem_in_n <= modem_level;
    end
endmodule

/* sim/uart_channel_reset_state_bench.sv */
// Self-checking bench for the channel register bank and its reset state.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module uart_channel_reset_state_bench
    import ucr_pkg::*;
;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready, rx_in, rx_held;
    logic        tx_out, rts_n, dtr_n, general_output_two_n, irq_out, irq_oe;
    logic        rx_transfer_ready_n, tx_transfer_ready_n, rx_level;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, modem_in_n, modem_level, m_old;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] seed;
    logic [7:0]  expv [6];
    int          num_errors, num_checks;
    localparam logic [7:0] REGS [6] = '{ADDR_DIV_LOW, ADDR_DIV_HIGH,
        ADDR_RESUME_1, ADDR_RESUME_2, ADDR_PAUSE_1, ADDR_PAUSE_2};

    ucr_channel ucr_channel_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_in, .modem_in_n,
        .rx_held, .tx_out, .rts_n, .dtr_n, .general_output_two_n,
        .rx_transfer_ready_n, .tx_transfer_ready_n, .irq_out, .irq_oe);
    ucr_line_peer ucr_line_peer_i (.aclk, .rx_level, .modem_level, .tx_out,
        .rx_in, .modem_in_n);

    // ************************************************************
    // Bus tasks and helpers.
    // ************************************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        logic ad, wd, bd;
        int   n;
        {ad, wd, bd} = 3'h0;
        n = 0;
        r = 2'h3;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bd && n < 40) begin
            @(negedge aclk);
            n++;
            ad = ad | (s_axi_awvalid & s_axi_awready);
            wd = wd | (s_axi_wvalid & s_axi_wready);
            if (s_axi_bvalid === 1'b1) begin
                bd = 1'b1;
                r = s_axi_bresp;
            end
            @(posedge aclk);
            if (ad) s_axi_awvalid <= 1'b0;
            if (wd) s_axi_wvalid <= 1'b0;
            if (bd) s_axi_bready <= 1'b0;
        end
        if (!bd) num_errors++;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        logic        ad, dn;
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        {ad, dn, n, d, r} = '0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!dn && n < 40) begin
            @(negedge aclk);
            n++;
            ad = ad | (s_axi_arvalid & s_axi_arready);
            if (s_axi_rvalid === 1'b1) begin
                dn = 1'b1;
                d = s_axi_rdata;
                r = s_axi_rresp;
            end
            @(posedge aclk);
            if (ad) s_axi_arvalid <= 1'b0;
            if (dn) s_axi_rready <= 1'b0;
        end
        if (!dn) num_errors++;
        `CHK(d, e)
        `CHK(r, er)
    endtask
    task automatic pulse_reset(input int n);
        @(posedge aclk);
        aresetn <= 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
        repeat (n) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic chk_idle();
        `CHK({tx_out, rts_n, dtr_n, general_output_two_n, rx_transfer_ready_n,
              tx_transfer_ready_n, irq_oe, irq_out}, 8'hf8)
        `CHK(rx_held, 1'b1)
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ************************************************************
    // Clock, watchdog and test sequence.
    // ************************************************************
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        end_of_test();
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, num_errors, num_checks} = '0;
        s_axi_wstrb = 4'hf;
        rx_level = 1'b1;
        modem_level = 4'h5;
        seed = 16'hbc7e;
        pulse_reset(12);
        chk_idle();
        rd_chk(ADDR_DIV_LOW, {24'h0, DIVISOR_INIT[7:0]},
               RESP_OKAY);
        rd_chk(ADDR_DIV_HIGH, {24'h0, DIVISOR_INIT[15:8]},
               RESP_OKAY);
        for (int i = 2; i < 6; i++) begin
            rd_chk(REGS[i], 32'h0, RESP_OKAY);
        end
        rd_chk(ADDR_MODEM_STATUS, {24'h0, ~modem_level, 4'h0},
               RESP_OKAY);
        $display("test power_up done");
        for (int k = 0; k < 12; k++) begin
            seed = lfsr(seed);
            expv[k % 6] = seed[7:0];
            axi_write(REGS[k % 6], {seed, seed}, resp);
            `CHK(resp, RESP_OKAY)
            rd_chk(REGS[k % 6], {24'h0, seed[7:0]}, RESP_OKAY);
        end
        s_axi_wstrb <= 4'he;
        axi_write(ADDR_RESUME_1, 32'h0000_00ff, resp);
        s_axi_wstrb <= 4'hf;
        `CHK(resp, RESP_OKAY)
        rd_chk(ADDR_RESUME_1, {24'h0, expv[2]}, RESP_OKAY);
        rd_chk(8'h20, 32'h0, RESP_SLVERR);
        rd_chk(8'h02, 32'h0, RESP_SLVERR);
        axi_write(8'h24, 32'h0000_00a5, resp);
        `CHK(resp, RESP_SLVERR)
        $display("test random_access done");
        axi_write(ADDR_CONTROL, 32'h0000_000e, resp);
        repeat (2) @(posedge aclk);
        `CHK({rts_n, dtr_n, general_output_two_n}, 3'h0)
        modem_level <= 4'ha;
        repeat (4) @(posedge aclk);
        pulse_reset(2);
        chk_idle();
        rd_chk(ADDR_DIV_LOW, {24'h0, expv[0]}, RESP_OKAY);
        rd_chk(ADDR_DIV_HIGH, {24'h0, expv[1]}, RESP_OKAY);
        for (int i = 2; i < 6; i++) begin
            rd_chk(REGS[i], 32'h0, RESP_OKAY);
        end
        rd_chk(ADDR_MODEM_STATUS, 32'h0000_0050, RESP_OKAY);
        $display("test pin_reset done");
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            m_old = modem_level;
            modem_level <= seed[3:0];
            repeat (4) @(posedge aclk);
            rd_chk(ADDR_MODEM_STATUS, {24'h0, ~seed[3:0], m_old ^ seed[3:0]},
                   RESP_OKAY);
            rd_chk(ADDR_MODEM_STATUS, {24'h0, ~seed[3:0], 4'h0}, RESP_OKAY);
        end
        $display("test modem_change done");
        rx_level <= 1'b0;
        axi_write(ADDR_CONTROL, 32'h0000_0001, resp);
        rx_level <= 1'b1;
        repeat (4) @(posedge aclk);
        `CHK(rx_held, 1'b0)
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h7;
        repeat (4) begin
            @(negedge aclk);
            `CHK({s_axi_awready, s_axi_wready, s_axi_arready}, 3'h0)
        end
        pulse_reset(2);
        chk_idle();
        rd_chk(ADDR_RESUME_1, 32'h0, RESP_OKAY);
        $display("test sleep done");
        end_of_test();
    end
endmodule
